// file: rtl/temp_sensor_defines.vh
/*
 Register map, field positions, reset values and timing counts of the
 temperature-monitoring register bank and its two-wire serial slave.
 Assumes inclusion by bare name from the design files.
*/
// Behaviour
// RL1: Temperature result 16-bit read-only, top ten bits
// RL2: Quarter degree steps, two's complement code
// RL3: Settings register top three bits select channel
// RL4: Channel code 0 sensor, 1-4 analog inputs
// RL5: Bits four, three: fault queue 1/2/4/6
// RL6: Bit two alarm polarity, bit one mode
// RL7: Bit zero shutdown, resets to normal operation
// RL8: Limit registers 16-bit, nine top bits used
// RL9: Conversion result read-only, unsigned top ten bits
// RL10: Code step equals reference over 1024
// RL11: Second settings: bit seven start mode, 355us
// RL12: Second settings bit six disables glitch filters
// RL13: Address: fixed upper nibble plus three pins
// RL14: Bus activity aborts conversion, restarts afterwards
// RL15: Start condition, then address and direction bit
// RL16: Matching slave acknowledges on ninth clock
// RL17: Nine clocks per byte, data stable high
// RL18: Master ends with stop or not-acknowledge
// RL19: Direction fixed for whole operation
// RL20: First write byte loads register pointer
// RL21: Pointer resets to temperature result register
// RL22: Sixteen-bit registers two bytes, settings one
// RL23: Most significant byte goes first
// RL24: Pointers six, seven write ignored, read zero
`ifndef TEMP_SENSOR_DEFINES_VH
`define TEMP_SENSOR_DEFINES_VH

`define REG_TEMPERATURE_RESULT 3'h0
`define REG_SETTINGS 3'h1
`define REG_RELEASE_LIMIT 3'h2
`define REG_TRIP_LIMIT 3'h3
`define REG_CONVERSION_RESULT 3'h4
`define REG_CONVERSION_SETTINGS 3'h5

`define SET_CHAN_HI 7
`define SET_CHAN_LO 5
`define SET_QUEUE_HI 4
`define SET_QUEUE_LO 3
`define SET_POLARITY 2
`define SET_MODE 1
`define SET_SHUTDOWN 0
`define CS2_START_MODE 7
`define CS2_FILTER_OFF 6

`define SETTINGS_RESET 8'h00
`define CONV_SETTINGS_RESET 8'h00
`define RELEASE_LIMIT_RESET 16'h4b00
`define TRIP_LIMIT_RESET 16'h5000
`define POINTER_RESET 8'h00
`define RELEASE_THRESH_RESET 9'h096
`define TRIP_THRESH_RESET 9'h0a0

`define CLK_MHZ 250
`define CONV_PERIOD_US 355
`define CONV_PERIOD_CYCLES (`CONV_PERIOD_US * `CLK_MHZ)
`define CONV_TIME_US 30
`define CONV_TIME_CYCLES (`CONV_TIME_US * `CLK_MHZ)
`define ADDR_UPPER_DEFAULT 4'h9

`endif

// file: rtl/bus_line_filter.v
/*
 Synchronises one serial bus line into the core clock and optionally
 removes glitches shorter than a few core cycles.
 Assumes an asynchronous pin input and a free-running core clock.
*/
`timescale 1ns/1ns
module bus_line_filter (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Line
  input wire lineIn,
  input wire filterOff,
  output reg lineOut
);
  reg meta;
  reg sync;
  reg [2:0] hist;

  always @(posedge clk) begin
    if (sys_rst) begin
      meta <= 1'b1;
      sync <= 1'b1;
      hist <= 3'h7;
      lineOut <= 1'b1;
    end else begin
      meta <= lineIn;
      sync <= meta;
      hist <= {hist[1:0], sync};
      if (filterOff)
        lineOut <= sync;
      else if (hist == 3'h7)
        lineOut <= 1'b1;
      else if (hist == 3'h0)
        lineOut <= 1'b0;
    end
  end
endmodule // bus_line_filter

// file: rtl/temp_sensor_register_slave.v
/*
 Register bank of a temperature-monitoring converter behind a two-wire
 serial slave. Holds the pointer, settings, limits and results, and runs
 the periodic conversion scheduler that bus traffic aborts and restarts.
 Assumes the analog converter core sits outside: it receives a start
 pulse and channel, and returns a 10-bit code with a done pulse.
*/
`timescale 1ns/1ns
`include "temp_sensor_defines.vh"
module temp_sensor_register_slave #(
  parameter [3:0] ADDR_UPPER = `ADDR_UPPER_DEFAULT,
  parameter [31:0] CONV_PERIOD = `CONV_PERIOD_CYCLES,
  parameter [31:0] CONV_TIME = `CONV_TIME_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Serial bus pins
  input wire serialClockIn,
  input wire serialDataIn,
  output reg serialDataOut,
  output reg serialDataOe,
  // Address select pins
  input wire [2:0] addressSelect,
  // Conversion start pin, active low
  input wire conversionStartPin_n,
  // Converter core
  output reg convStart,
  output reg [2:0] convChannel,
  input wire convDone,
  input wire [9:0] convCode,
  // Configuration to the alarm logic
  output reg [1:0] faultQueueCode,
  output reg alarmPolarity,
  output reg alarmLatched,
  output reg shutdown,
  output reg [8:0] releaseThreshold,
  output reg [8:0] tripThreshold,
  output reg alarmClear
);
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_AACK = 3'h2;
  localparam S_WBYTE = 3'h3;
  localparam S_WACK = 3'h4;
  localparam S_RBYTE = 3'h5;
  localparam S_RACK = 3'h6;

  reg [7:0] settings;
  reg [7:0] conversionSettings;
  reg [15:0] releaseLimit;
  reg [15:0] tripLimit;
  reg [9:0] temperatureCode;
  reg [9:0] conversionCode;
  reg [7:0] pointer;

  reg [2:0] state;
  reg [3:0] bitCnt;
  reg [7:0] shiftReg;
  reg readDir;
  reg firstByte;
  reg byteIdx;
  reg sclPrev;
  reg sdaPrev;
  reg [7:0] hiHold;
  reg [2:0] addrMeta;
  reg [2:0] addrPins;
  reg [1:0] cstSync;
  reg cstPrev;
  reg [31:0] timer;
  reg busy;
  reg [2:0] busyChan;
  reg busActive;

  wire scl;
  wire sda;
  wire sclRise = scl & ~sclPrev;
  wire sclFall = ~scl & sclPrev;
  wire startCond = scl & sclPrev & sdaPrev & ~sda; // RL15
  wire stopCond = scl & sclPrev & ~sdaPrev & sda;

  bus_line_filter clockFilter (
    .clk(clk),
    .sys_rst(sys_rst),
    .lineIn(serialClockIn),
    .filterOff(conversionSettings[`CS2_FILTER_OFF]), // RL12
    .lineOut(scl)
  );

  bus_line_filter dataFilter (
    .clk(clk),
    .sys_rst(sys_rst),
    .lineIn(serialDataIn),
    .filterOff(conversionSettings[`CS2_FILTER_OFF]), // RL12
    .lineOut(sda)
  );

  // Byte to send for a given pointer and byte position
  function [7:0] read_byte;
    input [2:0] sel;
    input idx;
    reg [15:0] word;
    begin
      word = 16'h0000;
      case (sel)
        `REG_TEMPERATURE_RESULT: word = {temperatureCode, 6'h00}; // RL1 RL2
        `REG_SETTINGS: word = {settings, 8'h00};
        `REG_RELEASE_LIMIT: word = {releaseLimit[15:7], 7'h00}; // RL8
        `REG_TRIP_LIMIT: word = {tripLimit[15:7], 7'h00}; // RL8
        `REG_CONVERSION_RESULT: word = {conversionCode, 6'h00}; // RL9
        `REG_CONVERSION_SETTINGS: word = {conversionSettings, 8'h00};
        default: word = 16'h0000; // RL24
      endcase
      read_byte = idx ? word[7:0] : word[15:8]; // RL23
    end
  endfunction

  // Does this register take two bytes
  function is_wide;
    input [2:0] sel;
    begin
      is_wide = (sel == `REG_TEMPERATURE_RESULT) || (sel == `REG_RELEASE_LIMIT) ||
        (sel == `REG_TRIP_LIMIT) || (sel == `REG_CONVERSION_RESULT); // RL22
    end
  endfunction

  // Byte loaded at the start of each read byte
  wire [7:0] txByte;
  assign txByte = read_byte(pointer[2:0], byteIdx);

  // Serial slave
  always @(posedge clk) begin
    if (sys_rst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      state <= S_IDLE;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      readDir <= 1'b0;
      firstByte <= 1'b0;
      byteIdx <= 1'b0;
      hiHold <= 8'h00;
      serialDataOut <= 1'b0;
      serialDataOe <= 1'b0;
      pointer <= `POINTER_RESET; // RL21
      settings <= `SETTINGS_RESET; // RL7
      conversionSettings <= `CONV_SETTINGS_RESET; // RL12
      releaseLimit <= `RELEASE_LIMIT_RESET;
      tripLimit <= `TRIP_LIMIT_RESET;
      busActive <= 1'b0;
      alarmClear <= 1'b0;
    end else begin
      sclPrev <= scl;
      sdaPrev <= sda;
      alarmClear <= 1'b0;
      if (startCond) begin
        state <= S_ADDR; // RL19
        bitCnt <= 4'h0;
        busActive <= 1'b1; // RL14
        serialDataOe <= 1'b0;
      end else if (stopCond) begin
        state <= S_IDLE;
        busActive <= 1'b0;
        serialDataOe <= 1'b0;
      end else begin
        case (state)
          S_ADDR, S_WBYTE: begin
            if (sclRise) begin
              shiftReg <= {shiftReg[6:0], sda}; // RL17
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              bitCnt <= 4'h0;
              if (state == S_ADDR) begin
                if (shiftReg[7:1] == {ADDR_UPPER, addrPins}) begin // RL13
                  readDir <= shiftReg[0]; // RL16
                  firstByte <= 1'b1;
                  byteIdx <= 1'b0;
                  serialDataOut <= 1'b0;
                  serialDataOe <= 1'b1; // RL16
                  state <= S_AACK;
                end else begin
                  // Foreign frame still counts as bus traffic until stop
                  state <= S_IDLE;
                end
              end else begin
                serialDataOut <= 1'b0;
                serialDataOe <= 1'b1;
                state <= S_WACK;
                if (firstByte) begin
                  pointer <= shiftReg; // RL20
                  firstByte <= 1'b0;
                  byteIdx <= 1'b0;
                end else begin
                  byteIdx <= ~byteIdx;
                  case (pointer[2:0])
                    `REG_SETTINGS: settings <= shiftReg; // RL3 RL5 RL6 RL7
                    `REG_CONVERSION_SETTINGS:
                      conversionSettings <= {shiftReg[7:6], 6'h00}; // RL11
                    `REG_RELEASE_LIMIT: begin
                      if (!byteIdx) begin
                        hiHold <= shiftReg; // RL23
                        releaseLimit <= {shiftReg, 8'h00};
                      end else
                        releaseLimit <= {hiHold, shiftReg[7], 7'h00}; // RL8
                    end
                    `REG_TRIP_LIMIT: begin
                      if (!byteIdx) begin
                        hiHold <= shiftReg; // RL23
                        tripLimit <= {shiftReg, 8'h00};
                      end else
                        tripLimit <= {hiHold, shiftReg[7], 7'h00}; // RL8
                    end
                    default: ; // RL24
                  endcase
                end
              end
            end
          end
          S_AACK, S_WACK: begin
            if (sclFall) begin
              if (readDir) begin
                shiftReg <= {txByte[6:0], 1'b0};
                serialDataOut <= txByte[7];
                serialDataOe <= 1'b1;
                bitCnt <= 4'h1;
                alarmClear <= 1'b1;
                state <= S_RBYTE;
              end else begin
                serialDataOe <= 1'b0;
                state <= S_WBYTE;
              end
            end
          end
          S_RBYTE: begin
            if (sclFall) begin
              if (bitCnt == 4'h8) begin
                serialDataOe <= 1'b0; // RL17
                bitCnt <= 4'h0;
                state <= S_RACK;
              end else begin
                serialDataOut <= shiftReg[7];
                shiftReg <= {shiftReg[6:0], 1'b0};
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          S_RACK: begin
            if (sclRise) begin
              if (sda) begin
                state <= S_IDLE; // RL18
              end else begin
                byteIdx <= is_wide(pointer[2:0]) ? ~byteIdx : 1'b0; // RL22
                state <= S_AACK;
              end
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // Conversion scheduler
  always @(posedge clk) begin
    if (sys_rst) begin
      addrMeta <= 3'h0;
      addrPins <= 3'h0;
      cstSync <= 2'h3;
      cstPrev <= 1'b1;
      timer <= 32'h0;
      busy <= 1'b0;
      busyChan <= 3'h0;
      convStart <= 1'b0;
      convChannel <= 3'h0;
      temperatureCode <= 10'h000;
      conversionCode <= 10'h000;
    end else begin
      addrMeta <= addressSelect;
      addrPins <= addrMeta; // RL13
      cstSync <= {cstSync[0], conversionStartPin_n};
      cstPrev <= cstSync[1];
      convStart <= 1'b0;
      convChannel <= settings[`SET_CHAN_HI:`SET_CHAN_LO]; // RL4
      if (busActive || settings[`SET_SHUTDOWN]) begin
        busy <= 1'b0; // RL14 RL7
        timer <= 32'h0;
      end else if (busy) begin
        if (convDone) begin
          busy <= 1'b0;
          if (busyChan == 3'h0)
            temperatureCode <= convCode; // RL2
          else
            conversionCode <= convCode; // RL10
        end
        timer <= timer + 32'h1;
      end else if (conversionSettings[`CS2_START_MODE]) begin
        if (cstPrev && !cstSync[1]) begin // RL11
          busy <= 1'b1;
          busyChan <= settings[`SET_CHAN_HI:`SET_CHAN_LO];
          convStart <= 1'b1;
        end
      end else if (timer == 32'h0 || timer >= CONV_PERIOD) begin // RL11
        busy <= 1'b1;
        busyChan <= settings[`SET_CHAN_HI:`SET_CHAN_LO];
        convStart <= 1'b1;
        timer <= 32'h1;
      end else
        timer <= timer + 32'h1;
    end
  end

  // Settings and limit fields to the alarm logic
  always @(posedge clk) begin
    if (sys_rst) begin
      faultQueueCode <= 2'h0;
      alarmPolarity <= 1'b0;
      alarmLatched <= 1'b0;
      shutdown <= 1'b0;
      releaseThreshold <= `RELEASE_THRESH_RESET;
      tripThreshold <= `TRIP_THRESH_RESET;
    end else begin
      faultQueueCode <= settings[`SET_QUEUE_HI:`SET_QUEUE_LO]; // RL5
      alarmPolarity <= settings[`SET_POLARITY]; // RL6
      alarmLatched <= settings[`SET_MODE]; // RL6
      shutdown <= settings[`SET_SHUTDOWN]; // RL7
      releaseThreshold <= releaseLimit[15:7];
      tripThreshold <= tripLimit[15:7];
    end
  end
endmodule // temp_sensor_register_slave

// file: bench/i2c_master_model.sv
/*
 Two-wire bus master model, stepped by the core clock.
 Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ns
module i2c_master_model (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic sdaLow
);
  // Low phase in core cycles, raised for a slow master
  int lowC = 12;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic bitIo(input logic b, output logic r);
    repeat (lowC / 2) @(posedge clk);
    sdaLow <= !b;
    repeat (lowC / 2) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic byteIo(input logic [7:0] d, input logic ackIn,
                        output logic [7:0] q, output logic ackOut);
    for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
    bitIo(ackIn, ackOut);
  endtask
  task automatic start();
    sdaLow <= 1'b1;
    repeat (4) @(posedge clk);
    scl <= 1'b0;
  endtask
  task automatic stop();
    repeat (lowC / 2) @(posedge clk);
    sdaLow <= 1'b1;
    repeat (lowC / 2) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sdaLow <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule // i2c_master_model

// file: bench/temp_sensor_checker.sv
/*
 Concurrent checks on the register slave's pins and outputs.
 Assumes it is bound to the slave and sees only its ports.
*/
`timescale 1ns/1ns
module temp_sensor_checker #(
  parameter logic [3:0] ADDR_UPPER = 4'h9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial bus
  input wire logic serialClockIn,
  input wire logic serialDataIn,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  input wire logic [2:0] addressSelect,
  // Converter and settings
  input wire logic convStart,
  input wire logic [1:0] faultQueueCode,
  input wire logic alarmPolarity,
  input wire logic alarmLatched,
  input wire logic shutdown,
  input wire logic [8:0] releaseThreshold,
  input wire logic [8:0] tripThreshold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic sclQ, sdaQ, first, inFrame;
  logic [3:0] bitCnt;
  logic [7:0] sh;
  wire sclRise = serialClockIn && !sclQ;
  wire startSeen = serialClockIn && sclQ && sdaQ && !serialDataIn;
  wire stopSeen = serialClockIn && sclQ && !sdaQ && serialDataIn;
  wire addrHit = sh[7:1] == {ADDR_UPPER, addressSelect};
  // Bit counter and frame tracking at the pins
  always @(posedge clk) begin
    sclQ <= serialClockIn;
    sdaQ <= serialDataIn;
    if (sys_rst || startSeen) begin
      bitCnt <= 4'h0;
      first <= 1'b1;
      inFrame <= !sys_rst;
    end else if (stopSeen) begin
      inFrame <= 1'b0;
    end else if (sclRise) begin
      sh <= {sh[6:0], serialDataIn};
      bitCnt <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
      if (bitCnt == 4'h8) first <= 1'b0;
    end
  end
  sequence sclLowLong;
    (!serialClockIn) [*8];
  endsequence
  sequence addrByteDone;
    sclRise && bitCnt == 4'h8 && first;
  endsequence
  reset_idle_a: assert property ($fell(sys_rst) |-> !serialDataOe && !convStart)
    else $error("Outputs busy after reset");
  bus_data_stable_a: assert property (serialClockIn && $past(serialClockIn) |->
    $stable(serialDataOe) && (!serialDataOe || $stable(serialDataOut)))
    else $error("Data line moved while clock high");
  shutdown_idle_a: assert property (shutdown && $past(shutdown) |-> !convStart)
    else $error("Conversion started in shutdown");
  busy_no_conv_a: assert property (sclLowLong |-> !convStart)
    else $error("Conversion started during bus traffic");
  addr_ack_a: assert property (addrByteDone ##0 addrHit |-> !serialDataIn)
    else $error("Own address not acknowledged");
  addr_reject_a: assert property (addrByteDone ##0 !addrHit |->
    serialDataIn && !serialDataOe)
    else $error("Foreign address acknowledged");
  cfg_in_frame_a: assert property ($changed({releaseThreshold, tripThreshold,
    faultQueueCode, alarmPolarity, alarmLatched, shutdown}) |-> inFrame)
    else $error("Settings changed outside a bus write");
  conv_pulse_a: assert property (convStart |=> !convStart)
    else $error("Start pulse longer than one cycle");
endmodule // temp_sensor_checker

bind temp_sensor_register_slave temp_sensor_checker #(.ADDR_UPPER(ADDR_UPPER)) chk (
  .clk, .sys_rst, .serialClockIn, .serialDataIn, .serialDataOut, .serialDataOe,
  .addressSelect, .convStart, .faultQueueCode, .alarmPolarity, .alarmLatched,
  .shutdown, .releaseThreshold, .tripThreshold
);

// file: bench/tb.sv
/*
 Self-checking bench for the register slave: bus master model, converter
 stand-in and one task per scenario. Assumes the checker is bound.
*/
`timescale 1ns/1ns
module tb;
  localparam logic [3:0] ADDR_UP = 4'h9;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] addressSelect = 3'h5;
  logic conversionStartPin_n = 1'b1;
  logic convDone = 1'b0;
  logic [9:0] convCode = 10'h3ff;
  logic serialDataOut, serialDataOe, convStart, alarmPolarity, alarmLatched;
  logic shutdown, alarmClear, scl, sdaLow;
  logic [2:0] convChannel;
  logic [1:0] faultQueueCode;
  logic [8:0] releaseThreshold, tripThreshold;
  wire sda = !(sdaLow || (serialDataOe && !serialDataOut));
  int mismatches = 0;
  int checks_done = 0;
  int convWait = 0;
  int starts = 0;
  always #2 clk = !clk;
  // Converter stand-in: done six cycles after start
  always @(posedge clk) begin
    convDone <= 1'b0;
    if (convStart) starts++;
    if (convStart) convWait <= 5;
    else if (convWait != 0) begin
      convWait <= convWait - 1;
      convDone <= (convWait == 1);
    end
  end
  i2c_master_model m (.clk(clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
  temp_sensor_register_slave #(.ADDR_UPPER(ADDR_UP), .CONV_PERIOD(32'd200),
    .CONV_TIME(32'd40)) dut (
    .clk(clk), .sys_rst(sys_rst), .serialClockIn(scl), .serialDataIn(sda),
    .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
    .addressSelect(addressSelect), .conversionStartPin_n(conversionStartPin_n),
    .convStart(convStart), .convChannel(convChannel), .convDone(convDone),
    .convCode(convCode), .faultQueueCode(faultQueueCode), .alarmPolarity(alarmPolarity),
    .alarmLatched(alarmLatched), .shutdown(shutdown), .releaseThreshold(releaseThreshold),
    .tripThreshold(tripThreshold), .alarmClear(alarmClear));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d);
    logic [7:0] q;
    logic a;
    m.start();
    m.byteIo({ADDR_UP, addressSelect, 1'b0}, 1'b1, q, a);
    check({15'h0, a}, 16'h0);
    m.byteIo(p, 1'b1, q, a);
    check({15'h0, a}, 16'h0);
    for (int k = 0; k < n; k++) begin
      m.byteIo(k ? d[7:0] : d[15:8], 1'b1, q, a);
      check({15'h0, a}, 16'h0);
    end
    m.stop();
  endtask
  task automatic rd(input logic [7:0] p, input int n, input logic [15:0] e);
    logic [7:0] q;
    logic [15:0] v;
    logic a;
    if (p != 8'hff) wr(p, 0, 16'h0);
    m.start();
    m.byteIo({ADDR_UP, addressSelect, 1'b1}, 1'b1, q, a);
    check({15'h0, a}, 16'h0);
    v = 16'h0;
    for (int k = 0; k < n; k++) begin
      m.byteIo(8'hff, k == n - 1, q, a);
      v = {v[7:0], q};
    end
    m.stop();
    check(v, e);
  endtask
  task automatic t_power_up();
    repeat (400) @(posedge clk);
    rd(8'hff, 2, 16'hffc0);
  endtask
  task automatic t_address();
    logic [7:0] q;
    logic a;
    for (int k = 0; k < 2; k++) begin
      m.start();
      m.byteIo(k ? {ADDR_UP, ~addressSelect, 1'b0} : {4'h5, addressSelect, 1'b0}, 1'b1, q, a);
      check({15'h0, a}, 16'h1);
      m.stop();
    end
    addressSelect <= 3'h2;
    repeat (4) @(posedge clk);
    rd(8'h00, 2, 16'hffc0);
  endtask
  task automatic t_limits();
    rd(8'h02, 2, 16'h4b00);
    rd(8'h03, 2, 16'h5000);
    m.lowC = 24;
    wr(8'h03, 2, 16'hc1ff);
    m.lowC = 12;
    check({7'h0, tripThreshold}, 16'h0183);
    rd(8'h03, 2, 16'hc180);
    wr(8'h02, 1, 16'h3c00);
    check({7'h0, releaseThreshold}, 16'h0078);
    rd(8'h02, 2, 16'h3c00);
  endtask
  task automatic t_settings();
    logic [7:0] v;
    for (int i = 0; i < 5; i++) begin
      v = {i[2:0], i[1:0], i[0], i[1], 1'b0};
      wr(8'h01, 1, {v, 8'h0});
      check({8'h0, convChannel, faultQueueCode, alarmPolarity, alarmLatched, shutdown},
        {8'h0, v});
      rd(8'h01, 1, {8'h0, v});
    end
    wr(8'h01, 1, 16'h0100);
    check({15'h0, shutdown}, 16'h1);
    repeat (300) @(posedge clk);
    wr(8'h01, 1, 16'h0000);
  endtask
  task automatic t_unmapped();
    for (int p = 6; p < 8; p++) begin
      wr(p[7:0], 1, 16'h5500);
      rd(p[7:0], 1, 16'h0000);
    end
  endtask
  task automatic t_start_mode();
    int n;
    wr(8'h05, 1, 16'hff00);
    rd(8'h05, 1, 16'h00c0);
    n = starts;
    repeat (400) @(posedge clk);
    check(16'(starts - n), 16'h0);
    conversionStartPin_n <= 1'b0;
    repeat (20) @(posedge clk);
    conversionStartPin_n <= 1'b1;
    check(16'(starts - n), 16'h1);
    wr(8'h05, 1, 16'h0000);
    n = starts;
    repeat (300) @(posedge clk);
    check({15'h0, starts > n}, 16'h1);
  endtask
  task automatic t_conversion();
    convCode <= 10'h201;
    wr(8'h01, 1, 16'h8000);
    repeat (400) @(posedge clk);
    rd(8'h04, 2, 16'h8040);
  endtask
  task automatic give_verdict();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
    t_power_up();
    t_address();
    t_limits();
    t_settings();
    t_unmapped();
    t_start_mode();
    t_conversion();
    give_verdict();
  end
endmodule // tb
